// [core/wtp_pkg.sv]
// shared constants of the postscaled watchdog block
package wtp_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 20; // 50 mhz system clock
	localparam int BASE_PERIOD_NS = 4_000_000; // 4 ms nominal base period
	// base period in clocks; exact division, no rounding needed
	localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
	// postscaler shape
	localparam int POST_WIDTH = 16; // postscaler counter width
	localparam int SEL_WIDTH = 4; // period-select field width
	localparam logic [3:0] SEL_RESET = 4'h0; // smallest tap
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	// field positions
	localparam int CTL_SOFT_EN_BIT = 0; // soft watchdog enable
	localparam int EVT_TIMEOUT_BIT = 0; // time-out event
	localparam int EVT_CLKFAIL_BIT = 1; // clock failure event
	localparam int EVT_CLEAR_BIT = 2; // clear/sleep restart event
	localparam int EVT_WIDTH = 3;
	localparam int ST_RUN_BIT = 0; // watchdog running
	localparam int ST_FLAG_BIT = 1; // time-out flag, low after time-out
	localparam int ST_OSC_BIT = 2; // rc oscillator enabled
	localparam int ST_SEL_LSB = 4; // period select copy
	localparam int ST_CNT_LSB = 16; // live postscaler count
	// values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [2:0] EVT_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic TIMEOUT_FLAG_RESET = 1'b1;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	// ahb transfer type bit that marks an active transfer
	localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : wtp_pkg

// [core/wtp_base_div.sv]
// base period divider running off the internal rc oscillator clock
`timescale 1ns/10ps
module wtp_base_div #(
	parameter int BASE_CYCLES = wtp_pkg::BASE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic run,
	input wire logic clr,
	// base period expiry pulse
	output logic tick
);
	localparam int CW = $clog2(BASE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(BASE_CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt; // clocks into the base period
		logic tick; // one-cycle expiry
	} wtp_div_t;

	wtp_div_t s_r;
	wtp_div_t s_nxt;

	// count clocks; stopped counter sits at zero so a restart is full length
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (clr || !run)
			s_nxt.cnt = '0;
		else if (s_r.cnt == LAST)
		begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.cnt = s_r.cnt + CW'(1);
	end

	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;
endmodule : wtp_base_div

// [core/wtp_postscale.sv]
// postscaler counter with a selectable power-of-two expiry tap
`timescale 1ns/10ps
module wtp_postscale #(
	parameter int WIDTH = wtp_pkg::POST_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// base ticks and control
	input wire logic tick,
	input wire logic clr,
	input wire logic [3:0] sel,
	// results
	output logic expire,
	output logic [WIDTH-1:0] count
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt; // base periods seen
		logic expire; // selected tap reached
	} wtp_post_t;

	wtp_post_t s_r;
	wtp_post_t s_nxt;

	// low bits that must be all ones for a ratio of 2**sel
	function automatic logic [WIDTH-1:0] tap_mask(input logic [3:0] s);
		logic [WIDTH:0] one;
		one = (WIDTH+1)'(1);
		tap_mask = WIDTH'((one << s) - (WIDTH+1)'(1));
	endfunction : tap_mask

	// ripple count of base expiries, tapped by the select field
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.expire = 1'b0;
		if (clr)
			s_nxt.cnt = '0;
		else if (tick)
		begin
			s_nxt.cnt = s_r.cnt + WIDTH'(1);
			// select field picks which tap expires
			if ((s_r.cnt & tap_mask(sel)) == tap_mask(sel))
				s_nxt.expire = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign expire = s_r.expire;
	assign count = s_r.cnt;
endmodule : wtp_postscale

// [core/wtp_watchdog.sv]
// watchdog top: enables, clears, time-out reset and ahb-lite registers
// How it works
// - watchdog runs on rc oscillator, enables it
// - base period nominally 4 ms
// - 16-bit postscaler counts base expiries
// - select field muxes the expiring postscaler tap
// - periods span 4 ms to about 131 s
// - sleep, clear, clock failure clear both counters
// - soft enable bit turns watchdog on/off
// - config enable forces watchdog on
// - software cannot disable a config-enabled watchdog
// - control register read/write, enable resets 0
// - upper 31 control bits read zero
// - select codes give power-of-two ratios
`timescale 1ns/10ps
module wtp_watchdog #(
	parameter int BASE_CYCLES = wtp_pkg::BASE_CYCLES,
	parameter int POST_WIDTH = wtp_pkg::POST_WIDTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// configuration word
	input wire logic CONFIG_WATCHDOG_ENABLE,
	input wire logic [3:0] PERIOD_SELECT,
	// core events, one-cycle pulses
	input wire logic SLEEP_INSTR,
	input wire logic CLEAR_WATCHDOG_INSTR,
	input wire logic PRIMARY_CLOCK_FAIL,
	input wire logic SECONDARY_CLOCK_FAIL,
	// outputs to the device
	output logic WATCHDOG_RESET,
	output logic TIMEOUT_FLAG,
	output logic INTERNAL_RC_OSC_EN,
	output logic IRQ
);
	localparam int EW = wtp_pkg::EVT_WIDTH;

	// whole block state
	typedef struct packed {
		logic soft_en; // soft watchdog enable
		logic [EW-1:0] evt; // sticky events
		logic [EW-1:0] mask; // interrupt mask
		logic wr_pend; // write data phase due
		logic [7:0] wr_ofs; // latched write offset
		logic [31:0] rdata; // read data register
		logic wdt_rst; // time-out reset pulse
		logic to_flag; // time-out flag, active low
		logic osc_en; // rc oscillator request
		logic irq; // interrupt level
	} wtp_state_t;

	wtp_state_t s_r;
	wtp_state_t s_nxt;

	// submodule wires
	logic run; // watchdog counting
	logic clr; // clear both counters
	logic tick; // base period expiry
	logic expire; // selected tap expiry
	logic [POST_WIDTH-1:0] post_cnt; // live postscaler count
	logic clk_fail; // either oscillator failed
	logic restart; // sleep or clear instruction
	logic addr_ph; // valid address phase
	logic [7:0] ofs; // address offset
	logic [EW-1:0] w1c; // bits written to clear

	// config enable overrides; soft bit only matters when it is off
	assign run = CONFIG_WATCHDOG_ENABLE | s_r.soft_en;
	assign clk_fail = PRIMARY_CLOCK_FAIL | SECONDARY_CLOCK_FAIL;
	assign restart = SLEEP_INSTR | CLEAR_WATCHDOG_INSTR;
	// a fired time-out also restarts the count for the next period
	assign clr = restart | clk_fail | s_r.wdt_rst | !run;

	// base period from the rc clock domain model
	wtp_base_div #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_base (
		.clk(CLK),
		.arst_n(ARST_N),
		.run(run),
		.clr(clr),
		.tick(tick)
	);

	// 16-bit postscaler and tap mux
	wtp_postscale #(
		.WIDTH(POST_WIDTH)
	) u_post (
		.clk(CLK),
		.arst_n(ARST_N),
		.tick(tick),
		.clr(clr),
		.sel(PERIOD_SELECT),
		.expire(expire),
		.count(post_cnt)
	);

	// bus decode helpers
	assign addr_ph = HSEL & HREADY & HTRANS[wtp_pkg::HTRANS_ACTIVE_BIT];
	assign ofs = HADDR[7:0];
	assign w1c = HWDATA[EW-1:0];

	// read mux over the register map
	function automatic logic [31:0] read_word(
		input logic [7:0] a,
		input wtp_state_t s,
		input logic r,
		input logic [3:0] sel,
		input logic [POST_WIDTH-1:0] c
	);
		logic [31:0] d;
		d = wtp_pkg::DATA_ZERO;
		case (a)
			wtp_pkg::OFS_CONTROL:
				// only bit 0 exists, the rest read zero
				d[wtp_pkg::CTL_SOFT_EN_BIT] = s.soft_en;
			wtp_pkg::OFS_STATUS:
				d[EW-1:0] = s.evt;
			wtp_pkg::OFS_MASK:
				d[EW-1:0] = s.mask;
			wtp_pkg::OFS_STATE:
			begin
				d[wtp_pkg::ST_RUN_BIT] = r;
				d[wtp_pkg::ST_FLAG_BIT] = s.to_flag;
				d[wtp_pkg::ST_OSC_BIT] = s.osc_en;
				d[wtp_pkg::ST_SEL_LSB +: 4] = sel;
				d[wtp_pkg::ST_CNT_LSB +: POST_WIDTH] = c;
			end
			default:
				// unmapped offsets read zero, still okay
				d = wtp_pkg::DATA_ZERO;
		endcase
		read_word = d;
	endfunction : read_word

	// next-state logic for bus, events, flag and reset pulse
	always_comb
	begin
		s_nxt = s_r;
		// oscillator follows the enable, runs as long as the watchdog does
		s_nxt.osc_en = run;
		// time-out only counts while enabled
		s_nxt.wdt_rst = expire & run;

		// address phase: latch write, prepare read data
		s_nxt.wr_pend = 1'b0;
		if (addr_ph)
		begin
			if (HWRITE)
			begin
				s_nxt.wr_pend = 1'b1;
				s_nxt.wr_ofs = ofs;
			end
			else
				s_nxt.rdata = read_word(ofs, s_r, run, PERIOD_SELECT,
					post_cnt);
		end

		// data phase: apply write
		if (s_r.wr_pend)
		begin
			case (s_r.wr_ofs)
				wtp_pkg::OFS_CONTROL:
					s_nxt.soft_en = HWDATA[wtp_pkg::CTL_SOFT_EN_BIT];
				wtp_pkg::OFS_STATUS:
					s_nxt.evt = s_r.evt & ~w1c;
				wtp_pkg::OFS_MASK:
					s_nxt.mask = w1c;
				default:
					// read-only or unmapped: write ignored
					s_nxt.soft_en = s_r.soft_en;
			endcase
		end

		// sticky events applied after clears, so a set wins
		if (s_r.wdt_rst)
			s_nxt.evt[wtp_pkg::EVT_TIMEOUT_BIT] = 1'b1;
		if (clk_fail)
			s_nxt.evt[wtp_pkg::EVT_CLKFAIL_BIT] = 1'b1;
		if (restart)
			s_nxt.evt[wtp_pkg::EVT_CLEAR_BIT] = 1'b1;

		// time-out flag: restart sets it, a time-out clears it and wins
		if (restart)
			s_nxt.to_flag = 1'b1;
		if (expire & run)
			s_nxt.to_flag = 1'b0;

		// level interrupt from unmasked sticky bits
		s_nxt.irq = |(s_nxt.evt & s_nxt.mask);
	end

	// state register; the reset pulse itself does not reset this block,
	// the device reset tree decides what it resets
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s_r.soft_en <= wtp_pkg::CONTROL_RESET[0];
			s_r.evt <= wtp_pkg::EVT_RESET;
			s_r.mask <= wtp_pkg::MASK_RESET;
			s_r.wr_pend <= 1'b0;
			s_r.wr_ofs <= wtp_pkg::OFS_CONTROL;
			s_r.rdata <= wtp_pkg::DATA_ZERO;
			s_r.wdt_rst <= 1'b0;
			s_r.to_flag <= wtp_pkg::TIMEOUT_FLAG_RESET;
			s_r.osc_en <= 1'b0;
			s_r.irq <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	// outputs from flops, HREADYOUT and HRESP tied off; zero wait states, always okay
	assign HRDATA = s_r.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign WATCHDOG_RESET = s_r.wdt_rst;
	assign TIMEOUT_FLAG = s_r.to_flag;
	assign INTERNAL_RC_OSC_EN = s_r.osc_en;
	assign IRQ = s_r.irq;
endmodule : wtp_watchdog

// [dv/wtp_monitor.sv]
// assertion checker bound to the postscaled watchdog top
`timescale 1ns/10ps
module wtp_monitor #(
	parameter int BASE_CYCLES = 8
) (
	// clock and reset
	input logic CLK,
	input logic ARST_N,
	// bus answer
	input logic HREADYOUT,
	input logic HRESP,
	// configuration and core events
	input logic CONFIG_WATCHDOG_ENABLE,
	input logic SLEEP_INSTR,
	input logic CLEAR_WATCHDOG_INSTR,
	input logic PRIMARY_CLOCK_FAIL,
	input logic SECONDARY_CLOCK_FAIL,
	// device side outputs
	input logic WATCHDOG_RESET,
	input logic TIMEOUT_FLAG,
	input logic INTERNAL_RC_OSC_EN,
	input logic IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// sleep and clear also restore the flag; failures only clear
	wire restart = SLEEP_INSTR | CLEAR_WATCHDOG_INSTR;
	wire any_clr = restart | PRIMARY_CLOCK_FAIL | SECONDARY_CLOCK_FAIL;
	a_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus answer not ready and okay");
	a_reset_pulse: assert property (WATCHDOG_RESET |=> !WATCHDOG_RESET)
		else $error("time-out reset longer than one cycle");
	a_flag_drop: assert property (WATCHDOG_RESET |-> !TIMEOUT_FLAG)
		else $error("flag high during time-out reset");
	a_flag_sticky: assert property (!TIMEOUT_FLAG && !restart |=> !TIMEOUT_FLAG)
		else $error("flag rose without sleep or clear");
	a_flag_restore: assert property (restart |=> TIMEOUT_FLAG || WATCHDOG_RESET)
		else $error("flag not restored by sleep or clear");
	// pipeline may still drain two cycles; a fresh count needs the base
	a_clear_holds: assert property (any_clr |-> ##3 !WATCHDOG_RESET [*5])
		else $error("time-out too soon after a clear");
	a_cfg_osc: assert property (CONFIG_WATCHDOG_ENABLE [*2] |-> INTERNAL_RC_OSC_EN)
		else $error("oscillator off while config enable set");
	a_off_quiet: assert property (!INTERNAL_RC_OSC_EN [*4] |-> !WATCHDOG_RESET)
		else $error("time-out while watchdog off");
	c_timeout: cover property (WATCHDOG_RESET);
	c_irq: cover property ($rose(IRQ));
	c_clear: cover property (any_clr && INTERNAL_RC_OSC_EN);
endmodule : wtp_monitor
bind wtp_watchdog wtp_monitor #(.BASE_CYCLES(BASE_CYCLES)) u_mon (
	.CLK(CLK), .ARST_N(ARST_N), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.CONFIG_WATCHDOG_ENABLE(CONFIG_WATCHDOG_ENABLE),
	.SLEEP_INSTR(SLEEP_INSTR), .CLEAR_WATCHDOG_INSTR(CLEAR_WATCHDOG_INSTR),
	.PRIMARY_CLOCK_FAIL(PRIMARY_CLOCK_FAIL),
	.SECONDARY_CLOCK_FAIL(SECONDARY_CLOCK_FAIL),
	.WATCHDOG_RESET(WATCHDOG_RESET), .TIMEOUT_FLAG(TIMEOUT_FLAG),
	.INTERNAL_RC_OSC_EN(INTERNAL_RC_OSC_EN), .IRQ(IRQ));

// [dv/test_watchdog_timer_postscaled.sv]
// self-checking bench for the postscaled watchdog block
`timescale 1ns/10ps
module test_watchdog_timer_postscaled;
	localparam int BC = 8; // short base period keeps the run brief
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	// bus master side
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	// config word and events: sleep, clear, primary, secondary fail
	logic cfg_en = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [3:0] ev = 4'h0;
	logic wd_rst;
	logic to_flag;
	logic osc_en;
	logic irq;
	// expected read data, oldest first
	logic [31:0] exp_q[$];
	logic rd_pend = 1'b0;
	logic [31:0] seed = 32'h30b7_9822;
	int fail_count = 0;
	int total_checks = 0;
	int rst_seen = 0;
	int i;
	int r0;

	always #10 clk = ~clk;

	wtp_watchdog #(.BASE_CYCLES(BC)) DUT (
		.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp),
		.CONFIG_WATCHDOG_ENABLE(cfg_en), .PERIOD_SELECT(sel),
		.SLEEP_INSTR(ev[0]), .CLEAR_WATCHDOG_INSTR(ev[1]),
		.PRIMARY_CLOCK_FAIL(ev[2]), .SECONDARY_CLOCK_FAIL(ev[3]),
		.WATCHDOG_RESET(wd_rst), .TIMEOUT_FLAG(to_flag),
		.INTERNAL_RC_OSC_EN(osc_en), .IRQ(irq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one single transfer; no wait-state count is assumed
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		rd_pend <= ~w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd_pend <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic pulse(input int k);
		ev <= 4'h1 << k;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pulse

	// counts edges until a time-out reset or the upper bound
	task automatic wait_wd(input int lo, input int hi, input logic want);
		int n;
		n = 0;
		while (wd_rst !== 1'b1 && n < hi)
		begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= lo}, 32'h1);
		check({31'h0, wd_rst}, {31'h0, want});
	endtask : wait_wd

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// read data checked in the data phase against the oldest note
	always @(posedge clk)
		if (rd_pend && exp_q.size() > 0)
			check(hrdata, exp_q.pop_front());

	always @(posedge clk)
		if (wd_rst === 1'b1)
			rst_seen++;

	// main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h00, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0002);
		rd(8'h10, 32'h0000_0000);
		check({31'h0, to_flag}, 32'h1);
		wait_wd(64, 64, 1'b0);
		// random upper bits must read back as zero
		seed = lfsr(seed);
		bus(1'b1, 8'h00, seed | 32'h0000_0001);
		rd(8'h00, 32'h0000_0001);
		check({31'h0, osc_en}, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			sel <= i[3:0];
			pulse(1);
			wait_wd(BC << i, (BC << i) + 8, 1'b1);
			@(posedge clk);
			check({31'h0, to_flag}, 32'h0);
		end
		// every clearing event, spaced under one period
		sel <= 4'h0;
		r0 = rst_seen;
		for (i = 0; i < 16; i++)
		begin
			pulse(i % 4);
			repeat (BC - 3) @(posedge clk);
		end
		check(rst_seen - r0, 32'h0000_0000);
		check({31'h0, to_flag}, 32'h1);
		bus(1'b1, 8'h00, 32'h0000_0000);
		wait_wd(64, 64, 1'b0);
		check({31'h0, osc_en}, 32'h0);
		cfg_en <= 1'b1;
		pulse(1);
		wait_wd(BC, BC + 8, 1'b1);
		rd(8'h00, 32'h0000_0000);
		// tap 12 run, then raise, mask and clear the interrupt
		sel <= 4'hC;
		bus(1'b1, 8'h04, 32'h0000_0007);
		pulse(1);
		wait_wd(BC << 12, (BC << 12) + 8, 1'b1);
		repeat (3) @(posedge clk);
		rd(8'h04, 32'h0000_0005);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h08, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h04, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd(8'h04, 32'h0000_0004);
		end_of_test();
	end

	// hang guard well past the expected run length
	initial
	begin
		#1_000_000;
		fail_count++;
		end_of_test();
	end
endmodule : test_watchdog_timer_postscaled
